//--- lfpc_checker.sv
/* checker for lfpc_pin_control: bus handshake and pin assertions.
   assumes one clock domain, clk_in, and the bind at the foot. */
`timescale 1ns/1ps
`default_nettype none
`include "lfpc_consts.svh"
module lfpc_checker (
	input wire logic        clk_in,                  // clock
	input wire logic        rstn_in,                 // reset, low
	input wire logic        if_reset_n_in,           // interface reset
	input wire logic        init_reset_n_in,         // second reset
	input wire logic [3:0]  bus_strap_code_in,       // strap code
	input wire logic [4:0]  general_input_pins_in,   // general inputs
	input wire logic        interface_select_pin_in, // mode select
	input wire logic        lad_oe_out,              // data drive
	input wire logic [7:0]  avs_address_in,          // address
	input wire logic        avs_read_in,             // read
	input wire logic        avs_write_in,            // write
	input wire logic [31:0] avs_readdata_out,        // read data
	input wire logic        avs_waitrequest_out      // stall
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// ==========================================================
	// handshake steps
	sequence s_req;
		(avs_read_in || avs_write_in) && avs_waitrequest_out;
	endsequence
	sequence s_ans;
		!avs_waitrequest_out ##1 avs_waitrequest_out;
	endsequence
	sequence s_rd(logic [7:0] a);
		avs_read_in && avs_waitrequest_out && avs_address_in == a;
	endsequence
	a_req_answer: assert property (s_req |=> s_ans)
		else $error("request not answered for exactly one cycle");
	a_idle_stall: assert property (!(avs_read_in || avs_write_in)
		|=> avs_waitrequest_out) else $error("answer without request");
	a_rdata_hold: assert property (!(avs_read_in && avs_waitrequest_out)
		|=> $stable(avs_readdata_out)) else $error("read data moved");
	a_unmapped_zero: assert property (s_rd(8'h1C)
		|=> avs_readdata_out == 32'h0000_0000) else $error("unmapped read");
	// ==========================================================
	// pins
	a_gpi_level: assert property ($stable(general_input_pins_in)[*3] ##0
		s_rd(`LFPC_OFF_GPI) |=> avs_readdata_out ==
		{27'h000_0000, $past(general_input_pins_in)})
		else $error("general input read wrong");
	a_strap_field: assert property ($stable(bus_strap_code_in)[*3] ##0
		s_rd(`LFPC_OFF_STATUS) |=> avs_readdata_out[13:9] ==
		{$past(bus_strap_code_in) == 4'h0, $past(bus_strap_code_in)})
		else $error("strap field wrong");
	a_rst_float: assert property (!if_reset_n_in[*4] |-> !lad_oe_out)
		else $error("data lines driven in reset");
	a_init_float: assert property ((!init_reset_n_in &&
		!interface_select_pin_in)[*4] |-> !lad_oe_out)
		else $error("data lines driven in second reset");
endmodule
bind lfpc_pin_control lfpc_checker i_lfpc_checker (.clk_in, .rstn_in,
	.if_reset_n_in, .init_reset_n_in, .bus_strap_code_in,
	.general_input_pins_in, .interface_select_pin_in, .lad_oe_out,
	.avs_address_in, .avs_read_in, .avs_write_in, .avs_readdata_out,
	.avs_waitrequest_out);
`default_nettype wire

//--- lfpc_consts.svh
/*
 * Offsets, field positions, reset values and counts of the flash pin
 * control block. Assumes inclusion by bare name.
 */
`ifndef LFPC_CONSTS_SVH
`define LFPC_CONSTS_SVH

// ==========================================================
// register byte offsets
`define LFPC_OFF_CMD     8'h00
`define LFPC_OFF_LOCK    8'h04
`define LFPC_OFF_STATUS  8'h08
`define LFPC_OFF_GPI     8'h0C
`define LFPC_OFF_ARRAY   8'h10
`define LFPC_OFF_CYCLES  8'h14
`define LFPC_OFF_MUX     8'h18

// ==========================================================
// command register fields
`define LFPC_CMD_SEC_LSB 0
`define LFPC_CMD_ERASE   4
`define LFPC_CMD_GO      5

// ==========================================================
// status register fields
`define LFPC_ST_BUSY     0
`define LFPC_ST_ACCEPT   1
`define LFPC_ST_REFUSE   2
`define LFPC_ST_RDARRAY  3
`define LFPC_ST_MUX      4
`define LFPC_ST_CYCLE    5
`define LFPC_ST_IFRST    6
`define LFPC_ST_TBL      7
`define LFPC_ST_WP       8
`define LFPC_ST_STRAP    9
`define LFPC_ST_BOOTDEV  13

// ==========================================================
// reset values and counts
`define LFPC_LOCK_RST    11'h000
`define LFPC_ARRAY_RST   11'h7FF
`define LFPC_TOP_SECTOR  4'hA
`define LFPC_BOOT_STRAP  4'h0
`define LFPC_OP_CYCLES   16
`define LFPC_CYC_NIBBLES 13

`endif

//--- lfpc_host_model.sv
/* host bus controller model: frames transfers and aborts them.
   assumes the bench holds go_in or abort_in high for one cycle or more. */
`timescale 1ns/1ps
`default_nettype none
module lfpc_host_model (
	input  wire logic       clk_in,      // bus clock
	input  wire logic       rstn_in,     // reset, low
	input  wire logic       go_in,       // open a transfer
	input  wire logic       abort_in,    // cut the current one
	output logic            frame_n_out, // frame, low
	output logic      [3:0] lad_out      // address and data
);
	logic [3:0] left;
	// frame held low for each cycle go_in or abort_in is high opens a transfer or cuts one short
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			frame_n_out <= 1'b1;
			lad_out <= 4'hF;
			left <= 4'h0;
		end else begin
			frame_n_out <= !(go_in || abort_in);
			if (go_in || abort_in) begin
				lad_out <= abort_in ? 4'hF : 4'h0;
				left <= abort_in ? 4'h0 : 4'hC;
			end else if (left != 4'h0) begin
				lad_out <= left;
				left <= left - 4'h1;
			end else begin
				lad_out <= ~lad_out; // released: no stale level
			end
		end
	end
endmodule
`default_nettype wire

//--- lfpc_pin_control.sv
/*
 * Pin control of a boot flash on a low-pin-count bus: cycle framing and
 * abort, interface resets, hardware sector protection, strap code,
 * general inputs and the address-multiplexed pin reuse.
 * Assumes an Avalon-MM master on clk_in and asynchronous pins.
 */
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "lfpc_consts.svh"

module lfpc_pin_control
	import lfpc_pkg::*;
#(
	parameter int OP_CYCLES  = `LFPC_OP_CYCLES,
	parameter int CYC_NIBBLE = `LFPC_CYC_NIBBLES
) (
	input  wire logic        clk_in,                 // 10 MHz clock
	input  wire logic        rstn_in,                // async reset, low
	input  wire logic        hub_frame_input_n_in,   // frame, low
	input  wire logic        if_reset_n_in,          // interface reset
	input  wire logic        init_reset_n_in,        // second reset
	input  wire logic        boot_sector_lock_pin_in,// low locks top
	input  wire logic        write_protect_n_in,     // low locks rest
	input  wire logic [3:0]  bus_strap_code_in,      // strap code
	input  wire logic [4:0]  general_input_pins_in,  // general inputs
	input  wire logic        interface_select_pin_in,// 1 = mux mode
	input  wire logic [3:0]  lad_in,                 // data lines in
	output logic      [3:0]  lad_out,                // data lines out
	output logic             lad_oe_out,             // data lines drive
	input  wire logic [7:0]  avs_address_in,         // byte address
	input  wire logic        avs_read_in,            // read request
	input  wire logic        avs_write_in,           // write request
	input  wire logic [31:0] avs_writedata_in,       // write data
	output logic      [31:0] avs_readdata_out,       // read data
	output logic             avs_waitrequest_out     // stall
);

	// ==========================================================
	// reset release
	logic [1:0] rst_sync;
	logic       rst_n;

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in)
			rst_sync <= 2'b00;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	// ==========================================================
	// pin synchronisers
	lfpc_pins_t pin_raw;
	lfpc_pins_t pin_meta;
	lfpc_pins_t pin;

	assign pin_raw = '{frame_n: hub_frame_input_n_in,
		if_rst_n: if_reset_n_in, init_n: init_reset_n_in,
		tbl_n: boot_sector_lock_pin_in, wp_n: write_protect_n_in,
		strap: bus_strap_code_in, gpi: general_input_pins_in,
		sel: interface_select_pin_in, lad: lad_in};

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta <= '0;
			pin      <= '0;
		end else begin
			pin_meta <= pin_raw;
			pin      <= pin_meta;
		end
	end

	// ==========================================================
	// interface mode and reset
	logic mux_mode;
	logic if_reset;

	// in mux mode the second reset pin serves as output enable
	assign if_reset = !pin.if_rst_n ||
		(!mux_mode && !pin.init_n);

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			mux_mode <= 1'b0;
		else if (if_reset || !rst_sync[1])
			mux_mode <= pin.sel;
	end

	// ==========================================================
	// bus cycle framing
	lfpc_state_t state;
	lfpc_state_t next_state;
	logic [4:0]  nib_cnt;
	logic [15:0] start_cnt;
	logic [15:0] abort_cnt;
	logic        frame_low;

	assign frame_low = !pin.frame_n && !mux_mode && !if_reset;

	always_comb begin
		next_state = state;
		unique case (state)
			LFPC_IDLE:
				if (frame_low)
					next_state = LFPC_START;
			LFPC_START:
				if (!frame_low)
					next_state = LFPC_ACTIVE;
			LFPC_ACTIVE:
				if (frame_low)
					next_state = LFPC_START;
				else if (nib_cnt == 5'(CYC_NIBBLE - 1))
					next_state = LFPC_IDLE;
			default:
				next_state = LFPC_IDLE;
		endcase
		if (if_reset || mux_mode)
			next_state = LFPC_IDLE;
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			state <= LFPC_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			nib_cnt <= '0;
		else if (state != LFPC_ACTIVE)
			nib_cnt <= '0;
		else
			nib_cnt <= nib_cnt + 5'd1;
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			start_cnt <= '0;
			abort_cnt <= '0;
		end else begin
			if (state == LFPC_IDLE && next_state == LFPC_START)
				start_cnt <= start_cnt + 16'd1;
			if (state == LFPC_ACTIVE && next_state == LFPC_START) begin
				start_cnt <= start_cnt + 16'd1;
				abort_cnt <= abort_cnt + 16'd1;
			end
		end
	end

	// ==========================================================
	// multiplexed programming pins
	logic        we_n_q;
	logic [10:0] mux_addr;
	logic [3:0]  mux_data;

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			we_n_q <= 1'b1;
		else
			we_n_q <= pin.frame_n;
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			mux_addr <= '0;
			mux_data <= '0;
		end else if (mux_mode && !if_reset &&
			!we_n_q && pin.frame_n) begin
			mux_addr <= {pin.gpi, pin.wp_n, pin.tbl_n,
				pin.strap};
			mux_data <= pin.lad;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			lad_oe_out <= 1'b0;
			lad_out    <= '0;
		end else begin
			lad_oe_out <= mux_mode && !if_reset &&
				!pin.init_n && pin.frame_n;
			lad_out    <= mux_data;
		end
	end

	// ==========================================================
	// register bus slave
	logic       rd_fire;
	logic       wr_fire;
	logic [5:0] cmd;
	logic [10:0] lock;
	logic [31:0] status_word;

	assign wr_fire = avs_write_in && !avs_waitrequest_out;
	assign rd_fire = avs_read_in && !avs_waitrequest_out;

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			avs_waitrequest_out <= 1'b1;
		else if (rd_fire || wr_fire)
			avs_waitrequest_out <= 1'b1;
		else if (avs_read_in || avs_write_in)
			avs_waitrequest_out <= 1'b0;
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			lock <= `LFPC_LOCK_RST;
		else if (wr_fire && avs_address_in == `LFPC_OFF_LOCK)
			lock <= avs_writedata_in[10:0];
	end

	// ==========================================================
	// program and erase automation
	logic        go;
	logic [3:0]  sec;
	logic        pin_forbid;
	logic        allowed;
	logic        busy;
	logic [$clog2(OP_CYCLES+1)-1:0] busy_cnt;
	logic        accepted;
	logic        refused;
	logic        read_array;
	logic [10:0] array_state;
	logic [3:0]  op_sec;
	logic        op_erase;

	assign go  = wr_fire && avs_address_in == `LFPC_OFF_CMD &&
		avs_writedata_in[`LFPC_CMD_GO];
	assign sec = avs_writedata_in[`LFPC_CMD_SEC_LSB +: 4];

	// pin protection: lock pin for top sector, write protect else
	assign pin_forbid = (sec == `LFPC_TOP_SECTOR) ?
		!pin.tbl_n :
		!pin.wp_n;
	assign allowed = go && !if_reset && !busy && !mux_mode &&
		sec <= `LFPC_TOP_SECTOR && !pin_forbid &&
		!lock[sec];

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			cmd <= '0;
		else if (wr_fire && avs_address_in == `LFPC_OFF_CMD)
			cmd <= avs_writedata_in[5:0];
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			busy     <= 1'b0;
			busy_cnt <= '0;
			op_sec   <= '0;
			op_erase <= 1'b0;
		end else if (if_reset) begin
			busy     <= 1'b0;
			busy_cnt <= '0;
		end else if (allowed) begin
			busy     <= 1'b1;
			busy_cnt <= '0;
			op_sec   <= sec;
			op_erase <= avs_writedata_in[`LFPC_CMD_ERASE];
		end else if (busy) begin
			busy_cnt <= busy_cnt + 1'b1;
			if (busy_cnt == ($bits(busy_cnt))'(OP_CYCLES - 1))
				busy <= 1'b0;
		end
	end

	// array model: a set bit means the sector reads erased
	genvar g;
	generate
		for (g = 0; g <= 10; g++) begin : g_sector
			always_ff @(posedge clk_in or negedge rst_n) begin
				if (!rst_n)
					array_state[g] <= 1'((`LFPC_ARRAY_RST) >> g);
				else if (busy && !if_reset && op_sec == 4'(g) &&
					busy_cnt == ($bits(busy_cnt))'(OP_CYCLES - 1))
					array_state[g] <= op_erase;
			end
		end
	endgenerate

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			read_array <= 1'b1;
		else if (if_reset)
			read_array <= 1'b1;
		else if (allowed)
			read_array <= 1'b0;
		else if (busy && busy_cnt ==
			($bits(busy_cnt))'(OP_CYCLES - 1))
			read_array <= 1'b1;
	end

	// sticky outcome flags, write one to clear, set wins
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			accepted <= 1'b0;
			refused  <= 1'b0;
		end else begin
			if (allowed)
				accepted <= 1'b1;
			else if (wr_fire && avs_address_in == `LFPC_OFF_STATUS &&
				avs_writedata_in[`LFPC_ST_ACCEPT])
				accepted <= 1'b0;
			if (go && !allowed)
				refused <= 1'b1;
			else if (wr_fire && avs_address_in == `LFPC_OFF_STATUS &&
				avs_writedata_in[`LFPC_ST_REFUSE])
				refused <= 1'b0;
		end
	end

	// ==========================================================
	// read data
	always_comb begin
		status_word = '0;
		status_word[`LFPC_ST_BUSY]    = busy;
		status_word[`LFPC_ST_ACCEPT]  = accepted;
		status_word[`LFPC_ST_REFUSE]  = refused;
		status_word[`LFPC_ST_RDARRAY] = read_array;
		status_word[`LFPC_ST_MUX]     = mux_mode;
		status_word[`LFPC_ST_CYCLE]   = state != LFPC_IDLE;
		status_word[`LFPC_ST_IFRST]   = if_reset;
		status_word[`LFPC_ST_TBL]     = pin.tbl_n;
		status_word[`LFPC_ST_WP]      = pin.wp_n;
		status_word[`LFPC_ST_STRAP +: 4] = pin.strap;
		status_word[`LFPC_ST_BOOTDEV] =
			pin.strap == `LFPC_BOOT_STRAP;
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			avs_readdata_out <= '0;
		else if (avs_read_in && avs_waitrequest_out) begin
			unique case (avs_address_in)
				`LFPC_OFF_CMD:    avs_readdata_out <= {26'h000_0000, cmd};
				`LFPC_OFF_LOCK:   avs_readdata_out <= {21'h00_0000, lock};
				`LFPC_OFF_STATUS: avs_readdata_out <= status_word;
				`LFPC_OFF_GPI:
					avs_readdata_out <= {27'h000_0000, pin.gpi};
				`LFPC_OFF_ARRAY:
					avs_readdata_out <= {21'h00_0000, array_state};
				`LFPC_OFF_CYCLES:
					avs_readdata_out <= {abort_cnt, start_cnt};
				`LFPC_OFF_MUX:
					avs_readdata_out <= {12'h000, mux_data, 5'h00,
						mux_addr};
				default:          avs_readdata_out <= '0;
			endcase
		end
	end

endmodule
`default_nettype wire

//--- lfpc_pkg.sv
/*
 * Types of the flash pin control block.
 * Assumes lfpc_consts.svh holds the numeric constants.
 */
package lfpc_pkg;

	// pin group sampled as one bundle
	typedef struct packed {
		logic       frame_n;
		logic       if_rst_n;
		logic       init_n;
		logic       tbl_n;
		logic       wp_n;
		logic [3:0] strap;
		logic [4:0] gpi;
		logic       sel;
		logic [3:0] lad;
	} lfpc_pins_t;

	typedef enum logic [1:0] {
		LFPC_IDLE   = 2'b00,
		LFPC_START  = 2'b01,
		LFPC_ACTIVE = 2'b10
	} lfpc_state_t;

endpackage

//--- tb_top.sv
/* register-level tests of lfpc_pin_control.
   assumes lfpc_host_model on the frame pin and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "lfpc_consts.svh"
module tb_top;
	logic        clk_in = 1'b0;
	logic        rstn_in = 1'b0;
	logic        if_n = 1'b1, init_n = 1'b1, boot_sector_lock_pin = 1'b1, wp_n = 1'b1;
	logic [3:0]  strap = 4'h5;
	logic [4:0]  gpi = 5'h0A;
	logic        sel = 1'b0;
	logic        go = 1'b0, abrt = 1'b0, frame_n, dut_oe, wait_rq;
	logic [3:0]  host_lad, dut_lad, lad_w;
	logic [7:0]  addr = 8'h00;
	logic        rd = 1'b0, wr = 1'b0;
	logic [31:0] wdata = 32'h0000_0000, rdata, d;
	int          bad_count = 0, comparisons = 0;
	localparam logic [31:0] zero = 32'h0000_0000;
	always #50 clk_in = ~clk_in;
	assign lad_w = dut_oe ? dut_lad : host_lad;
	lfpc_pin_control #(.OP_CYCLES(4)) i_lfpc_pin_control (.clk_in, .rstn_in,
		.hub_frame_input_n_in(frame_n), .if_reset_n_in(if_n),
		.init_reset_n_in(init_n), .boot_sector_lock_pin_in(boot_sector_lock_pin),
		.write_protect_n_in(wp_n), .bus_strap_code_in(strap),
		.general_input_pins_in(gpi), .interface_select_pin_in(sel),
		.lad_in(lad_w), .lad_out(dut_lad), .lad_oe_out(dut_oe),
		.avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wdata), .avs_readdata_out(rdata),
		.avs_waitrequest_out(wait_rq));
	lfpc_host_model i_lfpc_host_model (.clk_in, .rstn_in, .go_in(go),
		.abort_in(abrt), .frame_n_out(frame_n), .lad_out(host_lad));
	// ==========================================================
	// access tasks
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge clk_in);
		addr <= a;
		wdata <= v;
		rd <= !w;
		wr <= w;
		do begin
			@(posedge clk_in);
			n++;
		end while (wait_rq !== 1'b0 && n < 50);
		d = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 50) bad_count++;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
		bus(1'b0, a, zero);
		chk(nm, d, e);
	endtask
	task automatic pins(input logic t, input logic w);
		boot_sector_lock_pin <= t;
		wp_n <= w;
		repeat (4) @(posedge clk_in);
	endtask
	task automatic op(input logic t, w, input logic [5:0] c,
		input logic [1:0] res, input logic [31:0] arr);
		int n;
		n = 0;
		pins(t, w);
		bus(1'b1, `LFPC_OFF_CMD, {26'h000_0000, c});
		do begin
			bus(1'b0, `LFPC_OFF_STATUS, zero);
			n++;
		end while (d[0] !== 1'b0 && n < 20);
		chk("outcome", {30'h0000_0000, d[2:1]}, {30'h0000_0000, res});
		bus(1'b1, `LFPC_OFF_STATUS, 32'h0000_0006);
		rdc(`LFPC_OFF_ARRAY, arr, "array");
	endtask
	task automatic end_of_test;
		$display("comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		#1_000_000;
		bad_count++;
		end_of_test();
	end
	// ==========================================================
	// tests
	initial begin
		repeat (8) @(posedge clk_in);
		rstn_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		rdc(`LFPC_OFF_LOCK, zero, "lock reset");
		rdc(`LFPC_OFF_ARRAY, 32'h0000_07FF, "array reset");
		bus(1'b0, `LFPC_OFF_STATUS, zero);
		chk("status", d & 32'h0000_3F88, 32'h0000_0B88);
		gpi <= 5'h15;
		strap <= 4'h0;
		repeat (4) @(posedge clk_in);
		rdc(`LFPC_OFF_GPI, 32'h0000_0015, "general inputs");
		bus(1'b0, `LFPC_OFF_STATUS, zero);
		chk("strap", d & 32'h0000_3E00, 32'h0000_2000);
		go <= 1'b1;
		@(posedge clk_in) go <= 1'b0;
		repeat (3) @(posedge clk_in) abrt <= 1'b1;
		@(posedge clk_in) abrt <= 1'b0;
		repeat (20) @(posedge clk_in);
		repeat (20) @(posedge clk_in) go <= 1'b1;
		@(posedge clk_in) go <= 1'b0;
		repeat (20) @(posedge clk_in);
		rdc(`LFPC_OFF_CYCLES, 32'h0001_0003, "cycles");
		op(1'b1, 1'b1, 6'h20, 2'b01, 32'h0000_07FE);
		op(1'b1, 1'b0, 6'h21, 2'b10, 32'h0000_07FE);
		op(1'b1, 1'b0, 6'h2A, 2'b01, 32'h0000_03FE);
		op(1'b0, 1'b1, 6'h3A, 2'b10, 32'h0000_03FE);
		bus(1'b1, `LFPC_OFF_LOCK, 32'h0000_0404);
		op(1'b1, 1'b1, 6'h3A, 2'b10, 32'h0000_03FE);
		op(1'b1, 1'b1, 6'h22, 2'b10, 32'h0000_03FE);
		op(1'b0, 1'b0, 6'h30, 2'b10, 32'h0000_03FE);
		rdc(`LFPC_OFF_LOCK, 32'h0000_0404, "lock kept");
		bus(1'b1, `LFPC_OFF_LOCK, zero);
		op(1'b1, 1'b1, 6'h30, 2'b01, 32'h0000_03FF);
		bus(1'b1, 8'h1C, 32'hFFFF_FFFF);
		rdc(8'h1C, zero, "unmapped");
		rdc(`LFPC_OFF_LOCK, zero, "lock after unmapped write");
		for (int k = 0; k < 2; k++) begin
			if_n <= k != 0;
			init_n <= k == 0;
			repeat (4) @(posedge clk_in);
			bus(1'b0, `LFPC_OFF_STATUS, zero);
			chk("in reset", d & 32'h0000_0040, 32'h0000_0040);
			bus(1'b1, `LFPC_OFF_CMD, 32'h0000_0023);
			repeat (8) @(posedge clk_in);
			rdc(`LFPC_OFF_ARRAY, 32'h0000_03FF, "blocked");
			if_n <= 1'b1;
			init_n <= 1'b1;
			repeat (4) @(posedge clk_in);
			bus(1'b0, `LFPC_OFF_STATUS, zero);
			chk("after reset", d & 32'h0000_0049, 32'h0000_0008);
		end
		sel <= 1'b1;
		if_n <= 1'b0;
		repeat (4) @(posedge clk_in);
		if_n <= 1'b1;
		repeat (4) @(posedge clk_in);
		bus(1'b0, `LFPC_OFF_STATUS, zero);
		chk("mux mode", d & 32'h0000_0010, 32'h0000_0010);
		go <= 1'b1;
		@(posedge clk_in) go <= 1'b0;
		repeat (6) @(posedge clk_in);
		rdc(`LFPC_OFF_MUX, 32'h000C_0570, "mux latch");
		init_n <= 1'b0;
		repeat (4) @(posedge clk_in);
		chk("mux drive", {27'h000_0000, dut_oe, dut_lad}, 32'h0000_001C);
		init_n <= 1'b1;
		repeat (4) @(posedge clk_in);
		chk("mux float", {31'h0000_0000, dut_oe}, zero);
		end_of_test();
	end
endmodule
`default_nettype wire
